// ==== ued_pkg.sv ====
package ued_pkg;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int unsigned CLK_HZ          = 200_000_000;
  localparam int unsigned SAMPLE_NS       = 1000;
  localparam int unsigned SAMPLE_CYC      =
    (SAMPLE_NS * (CLK_HZ / 1_000_000)) / 1000;
  localparam int unsigned HOLDOFF_STEP_NS = 16000;
  localparam int unsigned HOLDOFF_STEP_CYC =
    (HOLDOFF_STEP_NS * (CLK_HZ / 1_000_000)) / 1000;

  // ==========================================================================
  // Register offsets (byte addresses, one word each)
  // ==========================================================================
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_DECIM    = 8'h04;
  localparam logic [7:0] ADDR_HOLDOFF  = 8'h08;
  localparam logic [7:0] ADDR_BP_B1    = 8'h0C;
  localparam logic [7:0] ADDR_BP_A2    = 8'h10;
  localparam logic [7:0] ADDR_BP_A3    = 8'h14;
  localparam logic [7:0] ADDR_LP_B1    = 8'h18;
  localparam logic [7:0] ADDR_LP_A2    = 8'h1C;
  localparam logic [7:0] ADDR_RESULT   = 8'h20;
  localparam logic [7:0] ADDR_FIFO_PTR = 8'h24;
  localparam logic [7:0] ADDR_MONITOR  = 8'h28;
  localparam logic [7:0] ADDR_TEMP     = 8'h2C;
  localparam logic [7:0] ADDR_FIFO_RA  = 8'h30;
  localparam logic [7:0] ADDR_FIFO_RD  = 8'h34;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int unsigned CTRL_ECHO_EN_BIT = 0;
  localparam int unsigned CTRL_ACTIVE_BIT  = 1;
  localparam int unsigned CTRL_FMT_LSB     = 2;
  localparam int unsigned CTRL_LPF_EN_BIT  = 4;
  localparam int unsigned MON_SRC_LSB      = 0;
  localparam int unsigned MON_TSDAC_EN_BIT = 2;
  localparam int unsigned MON_TSDAC_SEL_BIT = 3;

  localparam logic [4:0]  CTRL_RST    = 5'h00;
  localparam logic [5:0]  DECIM_RST   = 6'h01;
  localparam logic [7:0]  HOLDOFF_RST = 8'h00;
  localparam logic [15:0] COEF_RST    = 16'h0000;
  localparam logic [3:0]  MONITOR_RST = 4'h0;

  localparam int unsigned COEF_FRAC = 14;

  // ==========================================================================
  // Enumerations
  // ==========================================================================
  typedef enum logic [1:0] {
    FMT_12   = 2'h0,
    FMT_MSB8 = 2'h1,
    FMT_LSB8 = 2'h2,
    FMT_MID8 = 2'h3
  } ued_fmt_t;

  localparam logic [1:0] MON_NONE = 2'h0;
  localparam logic [1:0] MON_DAC  = 2'h1;

  typedef enum logic [2:0] {
    ST_OFF  = 3'h1,
    ST_HOLD = 3'h2,
    ST_RUN  = 3'h4
  } ued_state_t;

endpackage : ued_pkg

// ==== ued_top.sv ====
// Design decisions made here: the register addresses and the Avalon-MM register port.
`timescale 1ns/1ps
// Behaviour
// - Bandpass biquad on each sample using three software-written coefficients.
// - Signed bandpass result is rectified to a non-negative magnitude.
// - Held peak takes the input only when input exceeds held value.
// - Decimator counts to ratio, then wraps to 0, outputs, clears peak.
// - One decimator output every ratio microseconds.
// - Optional first-order lowpass on decimator outputs, two coefficients.
// - Latest-result register updates with each datapath output.
// - Outputs written to FIFO RAM in 12-bit or 8-bit selectable formats.
// - Enable low: no computation, no FIFO writes, filter histories zero.
// - Enable high: compute at once while active mode is set, FIFO writes after holdoff expires.
// - Holdoff register is 8 bits, 16 microseconds per count.
// - DAC gets datapath output only in 8-bit style formats.
// - DAC gets selected 8-bit value; code is zero while not routed.
// - Monitor pin routed to nothing after reset until software selects.
// - Temperature reading frozen while monitor pin carries datapath output.
// - Shared sensor/DAC enable needed; select bit picks sensor or DAC.
// - Converter feeds only this path, enabled only in active mode.
// - FIFO pointer holds last byte written; steps 2 or 1.
// - FIFO pointer zero at reset and on enable rise; contents kept.
// - FIFO RAM readable by processor while the path writes.
module ued_top #(
  parameter int unsigned FIFO_DEPTH = 768,
  parameter int unsigned ADC_W      = 12,
  parameter int unsigned COEF_W     = 16
) (
  input  wire logic              REF_CLK_I,
  input  wire logic              ARST_N_I,
  input  wire logic [7:0]        AVS_ADDRESS_I,
  input  wire logic              AVS_READ_I,
  input  wire logic              AVS_WRITE_I,
  input  wire logic [31:0]       AVS_WRITEDATA_I,
  input  wire logic [3:0]        AVS_BYTEENABLE_I,
  output logic      [31:0]       AVS_READDATA_O,
  output logic                   AVS_WAITREQUEST_O,
  input  wire logic [ADC_W-1:0]  ADC_DATA_I,
  output logic                   ADC_ENABLE_O,
  output logic                   ADC_CONVERT_O,
  input  wire logic [7:0]        TEMP_CODE_I,
  output logic                   TEMP_SENSOR_EN_O,
  output logic      [7:0]        DAC_CODE_O,
  output logic                   DAC_OUT_EN_O
);

  localparam int unsigned PTR_W  = $clog2(FIFO_DEPTH);
  localparam int unsigned SDIV_W = $clog2(ued_pkg::SAMPLE_CYC);
  localparam int unsigned HDIV_W = $clog2(ued_pkg::HOLDOFF_STEP_CYC);
  localparam logic [PTR_W:0] DEPTH_V = (PTR_W+1)'(FIFO_DEPTH);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic signed [15:0] sat16(input logic signed [33:0] v);
    if (v > 34'sd32767) begin
      sat16 = 16'sh7FFF;
    end else if (v < -34'sd32768) begin
      sat16 = -16'sh8000;
    end else begin
      sat16 = v[15:0];
    end
  endfunction : sat16

  function automatic logic [11:0] clamp12(input logic signed [15:0] v);
    if (v < 16'sh0000) begin
      clamp12 = 12'h000;
    end else if (v > 16'sh0FFF) begin
      clamp12 = 12'hFFF;
    end else begin
      clamp12 = v[11:0];
    end
  endfunction : clamp12

  function automatic logic [PTR_W-1:0] wrap(input logic [PTR_W:0] v);
    logic [PTR_W:0] d;
    d    = v - DEPTH_V;
    wrap = (v >= DEPTH_V) ? d[PTR_W-1:0] : v[PTR_W-1:0];
  endfunction : wrap

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    merge = (old & ~m) | (wd & m);
  endfunction : merge

  // ==========================================================================
  // Register file
  // ==========================================================================
  logic [4:0]        ctrl_r,               ctrl_nxt;
  logic [5:0]        decim_r,              decim_nxt;
  logic [7:0]        fifo_write_holdoff_r, fifo_write_holdoff_nxt;
  logic [15:0]       bandpass_coef_b1_r,   bandpass_coef_b1_nxt;
  logic [15:0]       bandpass_coef_a2_r,   bandpass_coef_a2_nxt;
  logic [15:0]       bandpass_coef_a3_r,   bandpass_coef_a3_nxt;
  logic [15:0]       lowpass_coef_b1_r,    lowpass_coef_b1_nxt;
  logic [15:0]       lowpass_coef_a2_r,    lowpass_coef_a2_nxt;
  logic [3:0]        monitor_r,            monitor_nxt;
  logic [PTR_W-1:0]  fifo_raddr_r,         fifo_raddr_nxt;
  logic [31:0]       rdata_r,              rdata_nxt;
  logic              ack_r,                ack_nxt;
  logic [31:0]       rd_mux;
  logic [11:0]       result_r;
  logic [PTR_W-1:0]  ptr_r;
  logic [7:0]        temperature_reading_r;
  logic [7:0]        fifo_mem [FIFO_DEPTH];
  logic              rd_take;

  // Reads take one wait cycle so the RAM read can be registered
  assign rd_take           = AVS_READ_I & ~ack_r;
  assign AVS_WAITREQUEST_O = rd_take;
  assign AVS_READDATA_O    = rdata_r;

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (AVS_ADDRESS_I)
      ued_pkg::ADDR_CTRL:     rd_mux[4:0]  = ctrl_r;
      ued_pkg::ADDR_DECIM:    rd_mux[5:0]  = decim_r;
      ued_pkg::ADDR_HOLDOFF:  rd_mux[7:0]  = fifo_write_holdoff_r;
      ued_pkg::ADDR_BP_B1:    rd_mux[15:0] = bandpass_coef_b1_r;
      ued_pkg::ADDR_BP_A2:    rd_mux[15:0] = bandpass_coef_a2_r;
      ued_pkg::ADDR_BP_A3:    rd_mux[15:0] = bandpass_coef_a3_r;
      ued_pkg::ADDR_LP_B1:    rd_mux[15:0] = lowpass_coef_b1_r;
      ued_pkg::ADDR_LP_A2:    rd_mux[15:0] = lowpass_coef_a2_r;
      ued_pkg::ADDR_RESULT:   rd_mux[11:0] = result_r;
      ued_pkg::ADDR_FIFO_PTR: rd_mux[PTR_W-1:0] = ptr_r;
      ued_pkg::ADDR_MONITOR:  rd_mux[3:0]  = monitor_r;
      ued_pkg::ADDR_TEMP:     rd_mux[7:0]  = temperature_reading_r;
      ued_pkg::ADDR_FIFO_RA:  rd_mux[PTR_W-1:0] = fifo_raddr_r;
      ued_pkg::ADDR_FIFO_RD:  rd_mux[7:0]  = fifo_mem[fifo_raddr_r];
      default:                rd_mux       = 32'h0000_0000;
    endcase
  end

  always_comb begin
    logic [31:0] wv;
    wv = 32'h0000_0000;
    ctrl_nxt               = ctrl_r;
    decim_nxt              = decim_r;
    fifo_write_holdoff_nxt = fifo_write_holdoff_r;
    bandpass_coef_b1_nxt   = bandpass_coef_b1_r;
    bandpass_coef_a2_nxt   = bandpass_coef_a2_r;
    bandpass_coef_a3_nxt   = bandpass_coef_a3_r;
    lowpass_coef_b1_nxt    = lowpass_coef_b1_r;
    lowpass_coef_a2_nxt    = lowpass_coef_a2_r;
    monitor_nxt            = monitor_r;
    fifo_raddr_nxt         = fifo_raddr_r;
    ack_nxt                = rd_take;
    rdata_nxt              = rd_take ? rd_mux : rdata_r;
    if (AVS_WRITE_I) begin
      wv = merge(rd_mux, AVS_WRITEDATA_I, AVS_BYTEENABLE_I);
      case (AVS_ADDRESS_I)
        ued_pkg::ADDR_CTRL:    ctrl_nxt               = wv[4:0];
        ued_pkg::ADDR_DECIM:   decim_nxt              = wv[5:0];
        ued_pkg::ADDR_HOLDOFF: fifo_write_holdoff_nxt = wv[7:0];
        ued_pkg::ADDR_BP_B1:   bandpass_coef_b1_nxt   = wv[15:0];
        ued_pkg::ADDR_BP_A2:   bandpass_coef_a2_nxt   = wv[15:0];
        ued_pkg::ADDR_BP_A3:   bandpass_coef_a3_nxt   = wv[15:0];
        ued_pkg::ADDR_LP_B1:   lowpass_coef_b1_nxt    = wv[15:0];
        ued_pkg::ADDR_LP_A2:   lowpass_coef_a2_nxt    = wv[15:0];
        ued_pkg::ADDR_MONITOR: monitor_nxt            = wv[3:0];
        ued_pkg::ADDR_FIFO_RA: fifo_raddr_nxt         = wrap({1'b0, wv[PTR_W-1:0]});
        default:               ;
      endcase
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctrl_r               <= ued_pkg::CTRL_RST;
      decim_r              <= ued_pkg::DECIM_RST;
      fifo_write_holdoff_r <= ued_pkg::HOLDOFF_RST;
      bandpass_coef_b1_r   <= ued_pkg::COEF_RST;
      bandpass_coef_a2_r   <= ued_pkg::COEF_RST;
      bandpass_coef_a3_r   <= ued_pkg::COEF_RST;
      lowpass_coef_b1_r    <= ued_pkg::COEF_RST;
      lowpass_coef_a2_r    <= ued_pkg::COEF_RST;
      monitor_r            <= ued_pkg::MONITOR_RST;
      fifo_raddr_r         <= '0;
      rdata_r              <= 32'h0000_0000;
      ack_r                <= 1'b0;
    end else begin
      ctrl_r               <= ctrl_nxt;
      decim_r              <= decim_nxt;
      fifo_write_holdoff_r <= fifo_write_holdoff_nxt;
      bandpass_coef_b1_r   <= bandpass_coef_b1_nxt;
      bandpass_coef_a2_r   <= bandpass_coef_a2_nxt;
      bandpass_coef_a3_r   <= bandpass_coef_a3_nxt;
      lowpass_coef_b1_r    <= lowpass_coef_b1_nxt;
      lowpass_coef_a2_r    <= lowpass_coef_a2_nxt;
      monitor_r            <= monitor_nxt;
      fifo_raddr_r         <= fifo_raddr_nxt;
      rdata_r              <= rdata_nxt;
      ack_r                <= ack_nxt;
    end
  end

  // ==========================================================================
  // Control decode
  // ==========================================================================
  logic              echo_en;
  logic              active_en;
  logic              lpf_en;
  ued_pkg::ued_fmt_t fmt;
  logic              sens_dac_en;
  logic              dac_route;

  assign echo_en     = ctrl_r[ued_pkg::CTRL_ECHO_EN_BIT];
  assign active_en   = ctrl_r[ued_pkg::CTRL_ACTIVE_BIT];
  assign lpf_en      = ctrl_r[ued_pkg::CTRL_LPF_EN_BIT];
  assign fmt         = ued_pkg::ued_fmt_t'(ctrl_r[ued_pkg::CTRL_FMT_LSB +: 2]);
  assign sens_dac_en = monitor_r[ued_pkg::MON_TSDAC_EN_BIT];
  // Datapath on monitor pin needs source, shared enable, DAC select and an 8-bit format
  assign dac_route   = (monitor_r[ued_pkg::MON_SRC_LSB +: 2] == ued_pkg::MON_DAC)
                     & sens_dac_en & monitor_r[ued_pkg::MON_TSDAC_SEL_BIT]
                     & (fmt != ued_pkg::FMT_12);

  assign ADC_ENABLE_O     = active_en;
  assign TEMP_SENSOR_EN_O = sens_dac_en & ~monitor_r[ued_pkg::MON_TSDAC_SEL_BIT];

  // ==========================================================================
  // Sample strobe and input synchronisers
  // ==========================================================================
  logic [SDIV_W-1:0] sdiv_r, sdiv_nxt;
  logic              tick;
  logic              conv_r;
  logic [ADC_W-1:0]  adc_s1_r, adc_s2_r;
  logic [7:0]        temp_s1_r, temp_s2_r;

  // Converter word is sampled once per microsecond; it must be stable then
  assign tick          = (sdiv_r == SDIV_W'(ued_pkg::SAMPLE_CYC - 1));
  assign sdiv_nxt      = tick ? '0 : sdiv_r + 1'b1;
  assign ADC_CONVERT_O = conv_r;

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      sdiv_r    <= '0;
      conv_r    <= 1'b0;
      adc_s1_r  <= '0;
      adc_s2_r  <= '0;
      temp_s1_r <= 8'h00;
      temp_s2_r <= 8'h00;
    end else begin
      sdiv_r    <= sdiv_nxt;
      conv_r    <= tick & active_en;
      adc_s1_r  <= ADC_DATA_I;
      adc_s2_r  <= adc_s1_r;
      temp_s1_r <= TEMP_CODE_I;
      temp_s2_r <= temp_s1_r;
    end
  end

  // ==========================================================================
  // Bandpass, rectifier, peak, decimator
  // ==========================================================================
  logic signed [ADC_W-1:0] x0, x1_r, x2_r, x1_nxt, x2_nxt;
  logic signed [15:0]      y1_r, y2_r, y1_nxt, y2_nxt, bp_y;
  logic signed [ADC_W:0]   bp_diff;
  logic signed [33:0]      bp_acc;
  logic [16:0]             mag;
  logic [11:0]             mag12, peak_r, peak_nxt, pk_in;
  logic [5:0]              cnt_r, cnt_nxt, ratio;
  logic [6:0]              cnt_p1;
  logic                    dec_v_r, dec_v_nxt;
  logic [11:0]             dec_val_r, dec_val_nxt;
  logic                    take;

  assign take    = tick & echo_en & active_en;
  assign x0      = adc_s2_r;
  assign bp_diff = (ADC_W+1)'(x0) - (ADC_W+1)'(x2_r);
  // Zeros at DC and Nyquist, poles from the two feedback terms
  assign bp_acc  = 34'($signed(bandpass_coef_b1_r) * bp_diff)
                 - 34'($signed(bandpass_coef_a2_r) * y1_r)
                 - 34'($signed(bandpass_coef_a3_r) * y2_r);
  assign bp_y    = sat16(bp_acc >>> ued_pkg::COEF_FRAC);
  assign mag     = bp_y[15] ? 17'(-$signed({bp_y[15], bp_y})) : 17'(bp_y);
  assign mag12   = (mag > 17'h00FFF) ? 12'hFFF : mag[11:0];
  assign pk_in   = (mag12 > peak_r) ? mag12 : peak_r;
  // Ratio 0 behaves as 1 so the path never stalls
  assign ratio   = (decim_r == 6'h00) ? 6'h01 : decim_r;
  assign cnt_p1  = {1'b0, cnt_r} + 7'h01;

  always_comb begin
    x1_nxt      = x1_r;
    x2_nxt      = x2_r;
    y1_nxt      = y1_r;
    y2_nxt      = y2_r;
    peak_nxt    = peak_r;
    cnt_nxt     = cnt_r;
    dec_v_nxt   = 1'b0;
    dec_val_nxt = dec_val_r;
    if (!echo_en) begin
      x1_nxt   = '0;
      x2_nxt   = '0;
      y1_nxt   = 16'sh0000;
      y2_nxt   = 16'sh0000;
      peak_nxt = 12'h000;
      cnt_nxt  = 6'h00;
    end else if (take) begin
      x1_nxt = x0;
      x2_nxt = x1_r;
      y1_nxt = bp_y;
      y2_nxt = y1_r;
      if (cnt_p1 == {1'b0, ratio}) begin
        cnt_nxt     = 6'h00;
        peak_nxt    = 12'h000;
        dec_v_nxt   = 1'b1;
        dec_val_nxt = pk_in;
      end else begin
        cnt_nxt  = cnt_p1[5:0];
        peak_nxt = pk_in;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      x1_r      <= '0;
      x2_r      <= '0;
      y1_r      <= 16'sh0000;
      y2_r      <= 16'sh0000;
      peak_r    <= 12'h000;
      cnt_r     <= 6'h00;
      dec_v_r   <= 1'b0;
      dec_val_r <= 12'h000;
    end else begin
      x1_r      <= x1_nxt;
      x2_r      <= x2_nxt;
      y1_r      <= y1_nxt;
      y2_r      <= y2_nxt;
      peak_r    <= peak_nxt;
      cnt_r     <= cnt_nxt;
      dec_v_r   <= dec_v_nxt;
      dec_val_r <= dec_val_nxt;
    end
  end

  // ==========================================================================
  // Lowpass and result stage
  // ==========================================================================
  logic [11:0]        lx1_r, lx1_nxt, result_nxt;
  logic signed [15:0] ly1_r, ly1_nxt, lp_y;
  logic signed [33:0] lp_acc;
  logic               res_v_r, res_v_nxt;

  assign lp_acc = 34'($signed(lowpass_coef_b1_r)
                      * $signed({2'b00, 13'(dec_val_r) + 13'(lx1_r)}))
                - 34'($signed(lowpass_coef_a2_r) * ly1_r);
  assign lp_y   = sat16(lp_acc >>> ued_pkg::COEF_FRAC);

  always_comb begin
    lx1_nxt    = lx1_r;
    ly1_nxt    = ly1_r;
    result_nxt = result_r;
    res_v_nxt  = 1'b0;
    if (!echo_en) begin
      lx1_nxt = 12'h000;
      ly1_nxt = 16'sh0000;
    end else if (dec_v_r) begin
      lx1_nxt    = dec_val_r;
      ly1_nxt    = lp_y;
      result_nxt = lpf_en ? clamp12(lp_y) : dec_val_r;
      res_v_nxt  = 1'b1;
    end
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      lx1_r    <= 12'h000;
      ly1_r    <= 16'sh0000;
      result_r <= 12'h000;
      res_v_r  <= 1'b0;
    end else begin
      lx1_r    <= lx1_nxt;
      ly1_r    <= ly1_nxt;
      result_r <= result_nxt;
      res_v_r  <= res_v_nxt;
    end
  end

  // ==========================================================================
  // Holdoff sequencer, FIFO pointer, monitor and temperature
  // ==========================================================================
  ued_pkg::ued_state_t st_r, st_nxt;
  logic [7:0]        hcnt_r, hcnt_nxt;
  logic [HDIV_W-1:0] hdiv_r, hdiv_nxt;
  logic [PTR_W-1:0]  ptr_nxt, wa1, wa2;
  logic              fifo_we;
  logic [7:0]        byte8, dac_r, dac_nxt, temp_nxt;

  assign wa1     = wrap({1'b0, ptr_r} + (PTR_W+1)'(1));
  assign wa2     = wrap({1'b0, ptr_r} + (PTR_W+1)'(2));
  assign fifo_we = res_v_r & (st_r == ued_pkg::ST_RUN) & echo_en;

  always_comb begin
    case (fmt)
      ued_pkg::FMT_LSB8: byte8 = result_r[7:0];
      ued_pkg::FMT_MID8: byte8 = result_r[9:2];
      default:           byte8 = result_r[11:4];
    endcase
  end

  always_comb begin
    st_nxt   = st_r;
    hcnt_nxt = hcnt_r;
    hdiv_nxt = hdiv_r;
    ptr_nxt  = ptr_r;
    case (st_r)
      ued_pkg::ST_OFF: begin
        if (echo_en) begin
          ptr_nxt  = '0;
          hcnt_nxt = fifo_write_holdoff_r;
          hdiv_nxt = '0;
          st_nxt   = (fifo_write_holdoff_r == 8'h00) ? ued_pkg::ST_RUN
                                                     : ued_pkg::ST_HOLD;
        end
      end
      ued_pkg::ST_HOLD: begin
        if (!echo_en) begin
          st_nxt = ued_pkg::ST_OFF;
        end else if (hdiv_r == HDIV_W'(ued_pkg::HOLDOFF_STEP_CYC - 1)) begin
          hdiv_nxt = '0;
          hcnt_nxt = hcnt_r - 8'h01;
          if (hcnt_r == 8'h01) begin
            st_nxt = ued_pkg::ST_RUN;
          end
        end else begin
          hdiv_nxt = hdiv_r + 1'b1;
        end
      end
      ued_pkg::ST_RUN: begin
        if (!echo_en) begin
          st_nxt = ued_pkg::ST_OFF;
        end else if (fifo_we) begin
          ptr_nxt = (fmt == ued_pkg::FMT_12) ? wa2 : wa1;
        end
      end
      default: st_nxt = ued_pkg::ST_OFF;
    endcase
  end

  assign dac_nxt  = !dac_route ? 8'h00 : (res_v_r ? byte8 : dac_r);
  // Sensor reading freezes while the pin shows the datapath
  assign temp_nxt = (tick & TEMP_SENSOR_EN_O & ~dac_route)
                  ? temp_s2_r : temperature_reading_r;
  assign DAC_CODE_O   = dac_r;
  assign DAC_OUT_EN_O = dac_route;

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_r                  <= ued_pkg::ST_OFF;
      hcnt_r                <= 8'h00;
      hdiv_r                <= '0;
      ptr_r                 <= '0;
      dac_r                 <= 8'h00;
      temperature_reading_r <= 8'h00;
    end else begin
      st_r                  <= st_nxt;
      hcnt_r                <= hcnt_nxt;
      hdiv_r                <= hdiv_nxt;
      ptr_r                 <= ptr_nxt;
      dac_r                 <= dac_nxt;
      temperature_reading_r <= temp_nxt;
    end
  end

  // RAM has no reset: contents survive enable toggles
  always_ff @(posedge REF_CLK_I) begin
    if (fifo_we) begin
      if (fmt == ued_pkg::FMT_12) begin
        fifo_mem[wa1] <= {4'h0, result_r[11:8]};
        fifo_mem[wa2] <= result_r[7:0];
      end else begin
        fifo_mem[wa1] <= byte8;
      end
    end
  end

endmodule : ued_top

// ==== ued_chk_asserts.sv ====
`timescale 1ns/1ps
module ued_chk (
  input wire logic        REF_CLK_I,
  input wire logic        ARST_N_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic        AVS_WAITREQUEST_O,
  input wire logic        ADC_ENABLE_O,
  input wire logic        ADC_CONVERT_O,
  input wire logic        TEMP_SENSOR_EN_O,
  input wire logic [7:0]  DAC_CODE_O,
  input wire logic        DAC_OUT_EN_O
);
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  // ==========
  // Port checks
  chk_read_wait: assert property ($rose(AVS_READ_I) |->
    AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O) else $error("read wait");
  chk_write_nowait: assert property (AVS_WRITE_I |->
    !AVS_WAITREQUEST_O) else $error("write wait");
  chk_rdata_hold: assert property (!AVS_READ_I |=>
    $stable(AVS_READDATA_O)) else $error("read data moved");
  chk_conv_gate: assert property (ADC_CONVERT_O |->
    ADC_ENABLE_O) else $error("convert while off");
  chk_conv_period: assert property (ADC_CONVERT_O |->
    ##1 !ADC_CONVERT_O [*8] ##192 (ADC_CONVERT_O || !ADC_ENABLE_O))
    else $error("sample period");
  // Code is registered, so allow it to settle after the route drops
  chk_dac_idle: assert property (!DAC_OUT_EN_O [*3] |->
    DAC_CODE_O == 8'h00) else $error("dac not idle");
  chk_share_excl: assert property (TEMP_SENSOR_EN_O |->
    !DAC_OUT_EN_O) else $error("sensor and dac");
  chk_dac_hold: assert property ($changed(DAC_CODE_O) ##1
    DAC_OUT_EN_O [*8] |-> $stable(DAC_CODE_O)) else $error("dac moved");
  cov_read: cover property (AVS_READ_I && !AVS_WAITREQUEST_O);
  cov_dac: cover property ($rose(DAC_OUT_EN_O));
  cov_conv: cover property (ADC_CONVERT_O);
endmodule : ued_chk

bind ued_top ued_chk chk_i (.*);

// ==== ued_adc_model.sv ====
`timescale 1ns/1ps
module ued_adc_model (
  input  wire logic        clk_i,
  input  wire logic        en_i,
  input  wire logic        conv_i,
  input  wire logic [11:0] val_i,
  output logic      [11:0] data_o = 12'h000
);
  // ==========
  // Converter word, held from strobe to strobe; junk while powered down
  always @(posedge clk_i) data_o <= !en_i ? ~data_o : conv_i ? val_i : data_o;
endmodule : ued_adc_model

// ==== test_ued_top.sv ====
`timescale 1ns/1ps
module test_ued_top;
  logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0;
  logic        wait_o, aen, conv, dac_en, ts_en;
  logic [7:0]  b8;
  logic [7:0]  addr = 8'h00, dac;
  logic [31:0] wdat = 32'h0, rdat, dat;
  logic [11:0] val = 12'h000, mag, adc;
  logic [40:0] expq[$];
  logic [40:0] e;
  int          fail_count = 0, comparisons = 0, cyc = 0, i;
  ued_top uut (
    .REF_CLK_I(clk), .ARST_N_I(rst_n), .AVS_ADDRESS_I(addr),
    .AVS_READ_I(rd), .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdat),
    .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wait_o), .ADC_DATA_I(adc), .ADC_ENABLE_O(aen),
    .ADC_CONVERT_O(conv), .TEMP_CODE_I(val[7:0]), .TEMP_SENSOR_EN_O(ts_en),
    .DAC_CODE_O(dac), .DAC_OUT_EN_O(dac_en));
  ued_adc_model adc_m (.clk_i(clk), .en_i(aen), .conv_i(conv),
    .val_i(val), .data_o(adc));
  initial forever #2.5 clk = ~clk;
  // ==========
  // Helpers
  function automatic logic [11:0] lfsr(input logic [11:0] s);
    return {s[10:0], s[11] ^ s[10] ^ s[9] ^ s[3]};
  endfunction : lfsr
  task automatic check(input logic [31:0] seen, exp, input string nm);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic conclude;
    if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  // For reads d is the expected word, c says whether it is compared
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic c);
    addr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    if (!w) expq.push_back({c, a, d});
    do @(posedge clk); while (wait_o !== 1'b0);
    dat = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic poll(input logic [31:0] v);
    dat = 'x;
    for (i = 0; i < 400 && dat !== v; i++) bus(1'b0, 8'h24, 32'h0, 1'b0);
    check(dat, v, "fifo pointer");
  endtask : poll
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      conclude();
    end
    if (rd && wait_o === 1'b0) begin
      e = expq.pop_front();
      if (e[40]) check(rdat, e[31:0], $sformatf("reg %h", e[39:32]));
    end
  end
  // ==========
  // Scenarios
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, 8'h04, 32'h1, 1'b1);
    bus(1'b0, 8'h3C, 32'h0, 1'b1);
    bus(1'b1, 8'h20, 32'hFFF, 1'b0);
    bus(1'b0, 8'h20, 32'h0, 1'b1);
    bus(1'b0, 8'h28, 32'h0, 1'b1);
    val <= lfsr(lfsr(12'h05A)) | 12'h800;
    bus(1'b1, 8'h0C, 32'h4000, 1'b0);
    bus(1'b1, 8'h04, 32'h2, 1'b0);
    bus(1'b1, 8'h28, 32'h4, 1'b0);
    check({31'h0, ts_en}, 32'h1, "sensor enable");
    bus(1'b1, 8'h28, 32'hD, 1'b0);
    check({31'h0, ts_en}, 32'h0, "sensor enable");
    bus(1'b1, 8'h00, 32'h2, 0);
    mag = ~val + 12'h001;
    repeat (400) @(posedge clk);
    for (int f = 0; f < 4; f++) begin
      b8 = (f == 1) ? mag[11:4] : (f == 2) ? mag[7:0] : mag[9:2];
      bus(1'b1, 8'h00, 32'h3 | (f << 2), 1'b0);
      poll(f ? 1 : 2);
      check({31'h0, dac_en}, f != 0, "dac enable");
      if (f) check({24'h0, dac}, {24'h0, b8}, "dac code");
      bus(1'b0, 8'h20, {20'h0, mag}, 1'b1);
      bus(1'b1, 8'h30, 32'h1, 1'b0);
      bus(1'b0, 8'h34, {24'h0, f ? b8 : {4'h0, mag[11:8]}}, 1);
      poll(f ? 2 : 4);
      bus(1'b0, 8'h20, 32'h0, 1'b1);
      bus(1'b1, 8'h00, 32'h2, 1'b0);
    end
    bus(1'b1, 8'h08, 32'h1, 1'b0);
    bus(1'b1, 8'h00, 32'h3, 1'b0);
    repeat (2800) @(posedge clk);
    bus(1'b0, 8'h24, 32'h0, 1'b1);
    poll(2);
    bus(1'b1, 8'h00, 32'h2, 1'b0);
    bus(1'b1, 8'h18, 32'h4000, 1'b0);
    bus(1'b1, 8'h04, 32'd25, 1'b0);
    bus(1'b1, 8'h00, 32'h13, 1'b0);
    repeat (6000) @(posedge clk);
    bus(1'b0, 8'h20, {20'h0, mag}, 1'b1);
    conclude();
  end
endmodule : test_ued_top
